/* analog_scaler.sv */
// Scales a raw quantity onto a 0..full-scale output code, saturating.
// Assumes span is nonzero and inputs hold steady for a few cycles.
`timescale 1ns/10ps
module analog_scaler #(
	parameter int W = 12
) (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic [31:0] value_in,
	input wire logic [31:0] span_in,
	output logic [W-1:0] code_out
);
	localparam logic [W-1:0] FULL = {W{1'b1}};
	logic [W-1:0] code_q, code_d;
	logic [63:0] prod;

	always_comb begin
		prod = {32'h0, value_in} * 64'(FULL);
		if (span_in == 32'h0 || value_in >= span_in) begin
			code_d = FULL;
		end else begin
			code_d = W'(prod / {32'h0, span_in});
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			code_q <= '0;
		end else begin
			code_q <= code_d;
		end
	end

	assign code_out = code_q;
endmodule

/* edge_sync.sv */
// Two-stage synchroniser with rising-edge pulse, for N discrete inputs.
// Assumes inputs are asynchronous pins.
`timescale 1ns/10ps
module edge_sync #(
	parameter int N = 1
) (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic [N-1:0] pin_in,
	output logic [N-1:0] level_out,
	output logic [N-1:0] rise_out
);
	logic [N-1:0] meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;

	always_comb begin
		meta_d = pin_in;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign level_out = sync_q;
	assign rise_out = sync_q & ~prev_q;
endmodule

/* io_gateway_pkg.sv */
// Constants shared by the discrete I/O interpreter and its helpers.
// Assumes analog values arrive as unsigned codes, full scale = 10 V.
package io_gateway_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int SETTLE_MS = 185;
	localparam int SETTLE_CYCLES = (CLK_HZ / 1000) * SETTLE_MS;
	localparam int ADC_W = 12;
	localparam int MODE_W = 3;
	localparam int SHOT_W = 7;
	localparam int ITEMS = 8;
	localparam int ZONES = 4;
	localparam logic [MODE_W-1:0] MODE_DISABLED = 3'h1;
	localparam logic [MODE_W-1:0] MODE_STANDBY = 3'h2;
	localparam logic [MODE_W-1:0] MODE_SHOT = 3'h3;
	localparam logic [MODE_W-1:0] MODE_OPERATOR = 3'h5;
	localparam logic [MODE_W-1:0] MODE_NIGHT = 3'h7;
	localparam logic [SHOT_W-1:0] SHOT_MIN = 7'h01;
	localparam logic [SHOT_W-1:0] SHOT_MAX = 7'h64;
	localparam logic [MODE_W-1:0] MODE_RESET = MODE_DISABLED;
	localparam logic [SHOT_W-1:0] SHOT_RESET = SHOT_MIN;
	// Pressure margins in hundredths of the unit: 500 psi, 34.5 bar, 3.45 MPa
	localparam logic [31:0] MARGIN_PSI = 32'h0000_C350;
	localparam logic [31:0] MARGIN_BAR = 32'h0000_0D7A;
	localparam logic [31:0] MARGIN_MPA = 32'h0000_0159;
	typedef enum logic [1:0] {UNIT_PSI, UNIT_BAR, UNIT_MPA} press_unit_t;
endpackage

/* plc_discrete_io_status_setpoint.sv */
// Discrete and analog I/O interpreter for an external controller.
// Assumes machine state arrives on mclk_in; controller pins are async.
//
// What this block does
// - Mode code driven on outputs 15-17
// - Shot number on outputs 18-24 in shot
// - Standby: output 24 shows valve locked
// - Standby: output 23 shows valve open
// - Standby: output 22 shows pump parked
// - Only analog input 1 used; others ignored
// - Analog input 1 full scale is setpoint span
// - Outputs 1,2 blue/red pressure, saturating at top
// - Pressure margin per unit: psi, bar, MPa
// - Output 3 blue pressure or combined flow
// - Eight items, at most four enabled zones
// - Zones assigned in fixed priority scan order
// - Secondary inputs 1-4 switch zones on/off
// - Inputs 5-8 pulse loads zone setpoint
// - Interlock: output 2 low if zone cold
// - Output 2 low during a dispense
// - Output 3 high during a dispense
// - Outputs 4-7 high while zone conditioning on
// - Mode code values 001,010,011,101,111
// - Shot code 1 to 100, others undefined
// - Output 4 high when last setpoint rejected
`timescale 1ns/10ps
module plc_discrete_io_status_setpoint
	import io_gateway_pkg::*;
#(
	parameter int AW = ADC_W,
	parameter int SETTLE = SETTLE_CYCLES
) (
	input wire logic mclk_in,
	input wire logic srst_in,
	// Machine state
	input wire logic [MODE_W-1:0] mode_in,
	input wire logic [SHOT_W-1:0] shot_in,
	input wire logic valve_locked_in,
	input wire logic valve_open_in,
	input wire logic pump_parked_in,
	input wire logic dispensing_in,
	input wire logic pressure_mode_in,
	input wire logic weight_flow_in,
	input wire press_unit_t unit_in,
	input wire logic [31:0] max_press_in,
	input wire logic [31:0] setpoint_min_in,
	input wire logic [31:0] pump_sum_in,
	input wire logic [31:0] pump_weighted_in,
	input wire logic [31:0] blue_press_in,
	input wire logic [31:0] red_press_in,
	input wire logic [31:0] flow_in,
	// Primary controller pins
	input wire logic setpoint_strobe_in,
	input wire logic [AW-1:0] analog1_in,
	input wire logic [AW-1:0] analog2_in,
	input wire logic [AW-1:0] analog3_in,
	input wire logic [AW-1:0] analog4_in,
	// Secondary unit
	input wire logic [ITEMS-1:0] item_enabled_in,
	input wire logic [ZONES-1:0] zone_switch_in,
	input wire logic [ZONES-1:0] zone_load_in,
	input wire logic [ZONES*AW-1:0] zone_analog_in,
	input wire logic second_gen_panel_in,
	input wire logic interlock_en_in,
	input wire logic [ZONES-1:0] zone_cold_in,
	input wire logic [ZONES-1:0] zone_active_in,
	// Primary outputs
	output logic [MODE_W-1:0] mode_code_out,
	output logic [SHOT_W-1:0] shot_bits_out,
	output logic setpoint_rejected_out,
	output logic [31:0] setpoint_out,
	output logic setpoint_load_out,
	output logic [AW-1:0] analog_blue_out,
	output logic [AW-1:0] analog_red_out,
	output logic [AW-1:0] analog_mix_out,
	// Secondary outputs
	output logic [ZONES*3-1:0] zone_item_out,
	output logic [ZONES-1:0] zone_valid_out,
	output logic [ZONES-1:0] zone_on_out,
	output logic [ZONES-1:0] zone_on_valid_out,
	output logic [ZONES-1:0] zone_sp_load_out,
	output logic [ZONES*AW-1:0] zone_sp_out,
	output logic sec_ready_out,
	output logic sec_dispense_out,
	output logic [ZONES-1:0] zone_status_out
);
	localparam logic [31:0] AFULL = 32'((1 << AW) - 1);

	function automatic logic [31:0] to_value(input logic [AW-1:0] code, input logic [31:0] span);
		logic [63:0] p;
		p = {{(64-AW){1'b0}}, code} * {32'h0, span};
		to_value = 32'(p / {32'h0, AFULL});
	endfunction

	function automatic logic mode_valid(input logic [MODE_W-1:0] m);
		mode_valid = (m == MODE_DISABLED) || (m == MODE_STANDBY) || (m == MODE_SHOT)
			|| (m == MODE_OPERATOR) || (m == MODE_NIGHT);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [AW-1:0] a1_m_q, a1_q;
	logic [ZONES*AW-1:0] za_m_q, za_q;
	logic strobe_lvl, strobe_rise;
	logic [ZONES-1:0] sw_lvl, load_rise;
	logic [ZONES-1:0] u_zone_load_lvl, u_zone_sw_rise;

	edge_sync #(.N(1)) u_strobe (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.pin_in(setpoint_strobe_in),
		.level_out(strobe_lvl),
		.rise_out(strobe_rise)
	);

	edge_sync #(.N(2*ZONES)) u_zone (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.pin_in({zone_load_in, zone_switch_in}),
		.level_out({u_zone_load_lvl, sw_lvl}),
		.rise_out({load_rise, u_zone_sw_rise})
	);

	// Analog pins are ignored except input 1 and the zone setpoint inputs
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			a1_m_q <= '0;
			a1_q <= '0;
			za_m_q <= '0;
			za_q <= '0;
		end else begin
			a1_m_q <= analog1_in;
			a1_q <= a1_m_q;
			za_m_q <= zone_analog_in;
			za_q <= za_m_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode and shot status
	logic [MODE_W-1:0] mode_q, mode_d;
	logic [SHOT_W-1:0] shot_q, shot_d;
	logic standby, shot_mode;

	always_comb begin
		standby = (mode_in == MODE_STANDBY);
		shot_mode = (mode_in == MODE_SHOT);
		mode_d = mode_valid(mode_in) ? mode_in : mode_q;
		shot_d = shot_q;
		if (shot_mode && shot_in >= SHOT_MIN && shot_in <= SHOT_MAX) begin
			shot_d = shot_in;
		end else if (standby) begin
			shot_d = {4'h0, pump_parked_in, valve_open_in, valve_locked_in};
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			mode_q <= MODE_RESET;
			shot_q <= SHOT_RESET;
		end else begin
			mode_q <= mode_d;
			shot_q <= shot_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Setpoint handshake: strobe must stay high for the settle time
	typedef enum logic [1:0] {SP_IDLE, SP_HOLD, SP_LOAD} sp_state_t;
	sp_state_t sp_q, sp_d;
	logic [31:0] cnt_q, cnt_d, sp_val_q, sp_val_d, span;
	logic rej_q, rej_d, load_q, load_d;
	logic [31:0] margin;

	always_comb begin
		case (unit_in)
			UNIT_BAR: margin = MARGIN_BAR;
			UNIT_MPA: margin = MARGIN_MPA;
			default: margin = MARGIN_PSI;
		endcase
	end

	always_comb begin
		span = pressure_mode_in ? max_press_in
			: (weight_flow_in ? pump_weighted_in : pump_sum_in);
		sp_d = sp_q;
		cnt_d = cnt_q;
		sp_val_d = sp_val_q;
		rej_d = rej_q;
		load_d = 1'b0;
		case (sp_q)
			SP_IDLE: begin
				cnt_d = '0;
				if (strobe_rise && mode_q == MODE_OPERATOR) begin
					sp_d = SP_HOLD;
				end else if (strobe_rise) begin
					rej_d = 1'b1;
				end
			end
			SP_HOLD: begin
				cnt_d = cnt_q + 32'h1;
				if (!strobe_lvl) begin
					sp_d = SP_IDLE;
				end else if (cnt_q >= 32'(SETTLE - 1)) begin
					sp_d = SP_LOAD;
					sp_val_d = to_value(a1_q, span);
					// Below minimum is refused, not clipped
					rej_d = (sp_val_d < setpoint_min_in) || (sp_val_d > span);
					load_d = !rej_d;
				end
			end
			SP_LOAD: begin
				// Wait for the strobe to drop so one pulse loads once
				if (!strobe_lvl) begin
					sp_d = SP_IDLE;
				end
			end
			default: sp_d = SP_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			sp_q <= SP_IDLE;
			cnt_q <= '0;
			sp_val_q <= '0;
			rej_q <= 1'b0;
			load_q <= 1'b0;
		end else begin
			sp_q <= sp_d;
			cnt_q <= cnt_d;
			sp_val_q <= sp_val_d;
			rej_q <= rej_d;
			load_q <= load_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Feedback scaling, pressure in hundredths of the unit
	logic [31:0] press_span, mix_val, mix_span;
	always_comb begin
		press_span = max_press_in + margin;
		mix_val = pressure_mode_in ? blue_press_in : flow_in;
		mix_span = pressure_mode_in ? press_span
			: (weight_flow_in ? pump_weighted_in : pump_sum_in);
	end

	analog_scaler #(.W(AW)) u_blue (
		.mclk_in(mclk_in), .srst_in(srst_in),
		.value_in(blue_press_in), .span_in(press_span), .code_out(analog_blue_out));
	analog_scaler #(.W(AW)) u_red (
		.mclk_in(mclk_in), .srst_in(srst_in),
		.value_in(red_press_in), .span_in(press_span), .code_out(analog_red_out));
	analog_scaler #(.W(AW)) u_mix (
		.mclk_in(mclk_in), .srst_in(srst_in),
		.value_in(mix_val), .span_in(mix_span), .code_out(analog_mix_out));

	////////////////////////////////////////////////////////////////////////
	// Secondary unit: zone assignment and status
	logic [ZONES*3-1:0] zitem_q, zitem_d;
	logic [ZONES-1:0] zval_q, zval_d, zon_q, zon_d, zonv_q, zonv_d, zld_q, zld_d, zst_q, zst_d;
	logic [ZONES*AW-1:0] zsp_q, zsp_d;
	logic rdy_q, rdy_d, disp_q, disp_d;
	logic [2:0] slot;

	always_comb begin
		zitem_d = '0;
		zval_d = '0;
		slot = '0;
		for (int i = 0; i < ITEMS; i++) begin
			// Items beyond the fourth enabled one get no zone
			if (item_enabled_in[i] && !zval_d[ZONES-1]) begin
				zitem_d[slot[1:0]*3 +: 3] = 3'(i);
				zval_d[slot[1:0]] = 1'b1;
				slot = slot + 3'h1;
			end
		end
		zon_d = sw_lvl & zval_q;
		zonv_d = zval_q;
		zld_d = load_rise & zval_q & {ZONES{second_gen_panel_in}};
		zsp_d = zsp_q;
		for (int z = 0; z < ZONES; z++) begin
			if (zld_d[z]) begin
				zsp_d[z*AW +: AW] = za_q[z*AW +: AW];
			end
		end
		rdy_d = !dispensing_in && !(interlock_en_in && |(zone_cold_in & zval_q));
		disp_d = dispensing_in;
		zst_d = zone_active_in & zval_q;
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			zitem_q <= '0;
			zval_q <= '0;
			zon_q <= '0;
			zonv_q <= '0;
			zld_q <= '0;
			zsp_q <= '0;
			rdy_q <= 1'b0;
			disp_q <= 1'b0;
			zst_q <= '0;
		end else begin
			zitem_q <= zitem_d;
			zval_q <= zval_d;
			zon_q <= zon_d;
			zonv_q <= zonv_d;
			zld_q <= zld_d;
			zsp_q <= zsp_d;
			rdy_q <= rdy_d;
			disp_q <= disp_d;
			zst_q <= zst_d;
		end
	end

	assign mode_code_out = mode_q;
	assign shot_bits_out = shot_q;
	assign setpoint_rejected_out = rej_q;
	assign setpoint_out = sp_val_q;
	assign setpoint_load_out = load_q;
	assign zone_item_out = zitem_q;
	assign zone_valid_out = zval_q;
	assign zone_on_out = zon_q;
	assign zone_on_valid_out = zonv_q;
	assign zone_sp_load_out = zld_q;
	assign zone_sp_out = zsp_q;
	assign sec_ready_out = rdy_q;
	assign sec_dispense_out = disp_q;
	assign zone_status_out = zst_q;
endmodule

/* plc_discrete_io_status_setpoint_assertions.sv */
// Concurrent checks on the ports of the I/O interpreter.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module io_gw_checker
	import io_gateway_pkg::*;
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic [MODE_W-1:0] mode_in,
	input wire logic valve_locked_in,
	input wire logic valve_open_in,
	input wire logic pump_parked_in,
	input wire logic dispensing_in,
	input wire logic interlock_en_in,
	input wire logic second_gen_panel_in,
	input wire logic [ZONES-1:0] zone_cold_in,
	input wire logic [ZONES-1:0] zone_active_in,
	input wire logic [ZONES-1:0] zone_load_in,
	input wire logic [MODE_W-1:0] mode_code_out,
	input wire logic [SHOT_W-1:0] shot_bits_out,
	input wire logic setpoint_load_out,
	input wire logic sec_ready_out,
	input wire logic sec_dispense_out,
	input wire logic [ZONES-1:0] zone_sp_load_out,
	input wire logic [ZONES-1:0] zone_valid_out,
	input wire logic [ZONES-1:0] zone_status_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (srst_in);
	////////////////////////////////////////////////////////////
	// Past values straddling reset are not trusted
	sequence s_run;
		!$past(srst_in);
	endsequence
	sequence s_stby;
		!$past(srst_in) && $past(mode_in) == MODE_STANDBY;
	endsequence
	sequence s_zone_ack;
		##[1:4] zone_sp_load_out[0];
	endsequence
	////////////////////////////////////////////////////////////
	a_mode_follow: assert property (s_run |-> mode_code_out == $past(mode_in))
		else $error("mode code lags mode input");
	a_stby_lock: assert property (s_stby |-> shot_bits_out[0] == $past(valve_locked_in))
		else $error("lock bit wrong in standby");
	a_stby_open: assert property (s_stby |-> shot_bits_out[1] == $past(valve_open_in))
		else $error("open bit wrong in standby");
	a_stby_park: assert property (s_stby |-> shot_bits_out[2] == $past(pump_parked_in))
		else $error("parked bit wrong in standby");
	a_disp_follow: assert property (s_run |-> sec_dispense_out == $past(dispensing_in))
		else $error("dispense flag wrong");
	a_ready_disp: assert property (s_run and $past(dispensing_in) |-> !sec_ready_out)
		else $error("ready high during dispense");
	a_ready_cold: assert property (
		s_run and $past(interlock_en_in && |zone_cold_in) |-> !sec_ready_out)
		else $error("ready high with a cold zone");
	a_load_single: assert property (setpoint_load_out |=> !setpoint_load_out)
		else $error("setpoint load longer than one cycle");
	a_zone_status: assert property (s_run |->
		zone_status_out == ($past(zone_active_in) & $past(zone_valid_out)))
		else $error("zone status wrong");
	a_zone_load: assert property (
		$rose(zone_load_in[0]) && second_gen_panel_in |-> s_zone_ack)
		else $error("zone setpoint load missing");
endmodule

bind plc_discrete_io_status_setpoint io_gw_checker u_chk (.mclk_in, .srst_in, .mode_in,
	.valve_locked_in, .valve_open_in, .pump_parked_in, .dispensing_in, .interlock_en_in,
	.second_gen_panel_in, .zone_cold_in, .zone_active_in, .zone_load_in, .mode_code_out,
	.shot_bits_out, .setpoint_load_out, .sec_ready_out, .sec_dispense_out, .zone_sp_load_out,
	.zone_valid_out, .zone_status_out);

/* plc_model.sv */
// Controller-side model that changes the setpoint over analog input 1.
// Assumes the bench raises go_in for one cycle with value_in steady.
`timescale 1ns/10ps
module plc_model #(
	parameter int HOLD = 8
) (
	input wire logic mclk_in,
	input wire logic go_in,
	input wire logic [11:0] value_in,
	output logic [11:0] analog_out,
	output logic strobe_out,
	output logic done_out
);
	initial begin
		analog_out = 12'h000;
		strobe_out = 1'b0;
		done_out = 1'b0;
		forever begin
			@(posedge go_in);
			done_out = 1'b0;
			analog_out = value_in;
			repeat (HOLD) @(negedge mclk_in);
			strobe_out = 1'b1;
			// Margin covers the input synchroniser lag
			repeat (HOLD + 6) @(negedge mclk_in);
			strobe_out = 1'b0;
			repeat (4) @(negedge mclk_in);
			done_out = 1'b1;
		end
	end
endmodule

/* testbench.sv */
// Self-checking bench for the discrete I/O interpreter.
// Assumes the checker binds itself and the settle count is shortened.
`timescale 1ns/10ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
$display("wrong value %s exp %0h got %0h", nm, e, a); end end
module testbench;
	import io_gateway_pkg::*;
	localparam int ST = 8;
	logic mclk_in = 1'b0, srst_in = 1'b1, valve_locked_in = 0, valve_open_in = 0;
	logic pump_parked_in = 0, dispensing_in = 0, pressure_mode_in = 1, weight_flow_in = 0;
	logic second_gen_panel_in = 0, interlock_en_in = 0, go = 0, done, setpoint_strobe_in;
	logic [MODE_W-1:0] mode_in = MODE_DISABLED, mode_code_out;
	logic [SHOT_W-1:0] shot_in = SHOT_MIN, shot_bits_out;
	press_unit_t unit_in = UNIT_PSI;
	logic [31:0] max_press_in = 32'h0003_0D40, setpoint_min_in = 0, pump_sum_in = 32'h118;
	logic [31:0] blue_press_in = 0, red_press_in = 0;
	logic [11:0] a1v = 12'h800, analog1_in, analog_blue_out, zone_item_out;
	logic [ITEMS-1:0] item_enabled_in = 0;
	logic [ZONES-1:0] zone_switch_in = 0, zone_load_in = 0, zone_cold_in = 0;
	logic [ZONES-1:0] zone_active_in = 0, zone_valid_out, zone_on_out, zone_status_out;
	logic [ZONES*12-1:0] zone_analog_in = 48'h0123_4567_89AB;
	logic setpoint_rejected_out, setpoint_load_out, sec_ready_out, sec_dispense_out;
	logic [31:0] setpoint_out;
	logic [ZONES*12-1:0] zone_sp_out;
	int n_mismatch = 0, total_checks = 0, nload = 0;
	plc_discrete_io_status_setpoint #(.SETTLE(ST)) uut (.mclk_in, .srst_in, .mode_in,
		.shot_in, .valve_locked_in, .valve_open_in, .pump_parked_in, .dispensing_in,
		.pressure_mode_in, .weight_flow_in, .unit_in, .max_press_in, .setpoint_min_in,
		.pump_sum_in, .pump_weighted_in(32'h100), .blue_press_in, .red_press_in,
		.flow_in(32'h0), .setpoint_strobe_in, .analog1_in, .analog2_in(12'h0),
		.analog3_in(12'h0), .analog4_in(12'h0), .item_enabled_in, .zone_switch_in,
		.zone_load_in, .zone_analog_in, .second_gen_panel_in, .interlock_en_in,
		.zone_cold_in, .zone_active_in, .mode_code_out, .shot_bits_out,
		.setpoint_rejected_out, .setpoint_out, .setpoint_load_out, .analog_blue_out,
		.analog_red_out(), .analog_mix_out(), .zone_item_out, .zone_valid_out, .zone_on_out,
		.zone_on_valid_out(), .zone_sp_load_out(), .zone_sp_out, .sec_ready_out,
		.sec_dispense_out, .zone_status_out);
	plc_model #(.HOLD(ST)) u_plc (.mclk_in, .go_in(go), .value_in(a1v),
		.analog_out(analog1_in), .strobe_out(setpoint_strobe_in), .done_out(done));
	initial forever #10 mclk_in = ~mclk_in;
	always @(posedge mclk_in) if (setpoint_load_out === 1'b1) nload <= nload + 1;
	////////////////////////////////////////////////////////////
	task automatic tick(int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic t_mode();
		logic [MODE_W-1:0] c [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
		foreach (c[i]) begin
			mode_in = c[i];
			tick(2);
			`CHK("mode", c[i], mode_code_out)
		end
		mode_in = MODE_SHOT;
		shot_in = SHOT_MAX;
		tick(2);
		`CHK("shot", SHOT_MAX, shot_bits_out)
		mode_in = MODE_STANDBY;
		for (int i = 0; i < 8; i++) begin
			{pump_parked_in, valve_open_in, valve_locked_in} = i[2:0];
			tick(2);
			`CHK("standby", i[2:0], shot_bits_out[2:0])
		end
		$display("status test done");
	endtask
	task automatic t_setp(logic [MODE_W-1:0] m, logic e_rej);
		mode_in = m;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		for (int k = 0; k < 200 && !done; k++) tick(1);
		`CHK("rejected", e_rej, setpoint_rejected_out)
		`CHK("loads", 1, nload)
		// 0x800 of full scale 0xFFF times span 200000
		if (!e_rej) `CHK("setpoint", 32'h0001_86B8, setpoint_out)
		$display("setpoint test done");
	endtask
	task automatic t_analog();
		blue_press_in = 32'h00FF_FFFF;
		tick(3);
		`CHK("blue", 12'hFFF, analog_blue_out)
		blue_press_in = 0;
		tick(3);
		`CHK("blue", 12'h000, analog_blue_out)
		$display("analog test done");
	endtask
	task automatic t_zone();
		item_enabled_in = 8'h69;
		zone_switch_in = 4'hA;
		zone_active_in = 4'h5;
		second_gen_panel_in = 1;
		zone_load_in = 4'h1;
		tick(5);
		`CHK("zones", 12'hD58, zone_item_out)
		`CHK("valid", 4'hF, zone_valid_out)
		`CHK("on", 4'hA, zone_on_out)
		`CHK("status", 4'h5, zone_status_out)
		`CHK("zone sp", 12'h9AB, zone_sp_out[11:0])
		item_enabled_in = 8'h14;
		zone_load_in = 4'h0;
		tick(3);
		`CHK("zones", 6'h22, zone_item_out[5:0])
		`CHK("valid", 4'h3, zone_valid_out)
		item_enabled_in = 8'hFF;
		dispensing_in = 1;
		tick(3);
		`CHK("zones", 12'h688, zone_item_out)
		`CHK("dispense", 1'b1, sec_dispense_out)
		`CHK("ready", 1'b0, sec_ready_out)
		dispensing_in = 0;
		interlock_en_in = 1;
		zone_cold_in = 4'h4;
		tick(3);
		`CHK("ready", 1'b0, sec_ready_out)
		zone_cold_in = 4'h0;
		tick(3);
		`CHK("ready", 1'b1, sec_ready_out)
		$display("zone test done");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		#200000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		tick(3);
		srst_in = 1'b0;
		tick(1);
		t_mode();
		t_setp(MODE_OPERATOR, 1'b0);
		t_setp(MODE_STANDBY, 1'b1);
		t_analog();
		t_zone();
		stop_test();
	end
endmodule
